//--- nvm_pkg.sv
/*
  shared constants and types for the eeprom program/erase/protect controller.
  assumes a 200 mhz system clock and a word-aligned apb register view.
*/
// Operation
// - armed protect bit permanently blocks program and erase of the sixteen secured bytes
// - secured bytes stay readable after arming; only changes are blocked
// - armed protection refuses program and erase of the configuration nv register
// - armed protection rejects block and bulk erase everywhere in the array
// - armed protection still allows byte program and byte erase of unprotected bytes
// - four 128-byte blocks, block-protect bit n guards block n
// - new block-protect setting applies after reset or a read of the nv register
// - zero divider lock-disable bit at reset locks live divider and divider nv registers
// - erased bits read one; delivered array bytes read all ones
// - program only clears bits, one to eight bits per operation
// - erase only sets bits, from one byte to the whole array
// - self-timed mode ends the cycle and clears high-voltage enable by timer
// - while latching only valid array writes latch; control writes wait for one
// - several valid writes while latching keep only the last address and data
// - array read while latching returns latched data and relatches the read address
// - high-voltage enable cannot be set without latch and a valid latched address
// - clearing latch and enable together clears only the enable
// - erase-select 00 program, 01 byte, 10 block, 11 bulk; protected block forbids
package nvm_pkg;

  // ----------------------------------------
  // clock and timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS         = 5;
  localparam int BYTE_PROGRAM_TIME_US  = 10;
  localparam int BYTE_ERASE_TIME_US    = 10;
  localparam int BLOCK_ERASE_TIME_US   = 10;
  localparam int BULK_ERASE_TIME_US    = 10;
  localparam int PROGRAM_CYCLES     = (BYTE_PROGRAM_TIME_US * 1000 + CLK_PERIOD_NS - 1)
                                      / CLK_PERIOD_NS;
  localparam int BYTE_ERASE_CYCLES  = (BYTE_ERASE_TIME_US * 1000 + CLK_PERIOD_NS - 1)
                                      / CLK_PERIOD_NS;
  localparam int BLOCK_ERASE_CYCLES = (BLOCK_ERASE_TIME_US * 1000 + CLK_PERIOD_NS - 1)
                                      / CLK_PERIOD_NS;
  localparam int BULK_ERASE_CYCLES  = (BULK_ERASE_TIME_US * 1000 + CLK_PERIOD_NS - 1)
                                      / CLK_PERIOD_NS;

  // ----------------------------------------
  // register indices (byte address = 4 x index)
  // ----------------------------------------
  localparam logic [15:0] ARRAY_BASE         = 16'h0800;
  localparam logic [15:0] ARRAY_LAST         = 16'h09ff;
  localparam logic [15:0] DIV_HIGH_NV_ADDR   = 16'hfe10;
  localparam logic [15:0] DIV_LOW_NV_ADDR    = 16'hfe11;
  localparam logic [15:0] DIV_HIGH_LIVE_ADDR = 16'hfe1a;
  localparam logic [15:0] DIV_LOW_LIVE_ADDR  = 16'hfe1b;
  localparam logic [15:0] CFG_NV_ADDR        = 16'hfe1c;
  localparam logic [15:0] CTL_ADDR           = 16'hfe1d;
  localparam logic [15:0] CFG_LIVE_ADDR      = 16'hfe1f;

  // ----------------------------------------
  // storage indices and field positions
  // ----------------------------------------
  localparam logic [9:0] ARRAY_BYTES      = 10'h200;
  localparam logic [9:0] DIV_HIGH_NV_IDX  = 10'h200;
  localparam logic [9:0] DIV_LOW_NV_IDX   = 10'h201;
  localparam logic [9:0] CFG_NV_IDX       = 10'h202;
  localparam int         LAST_IDX         = 514;
  localparam logic [4:0] SECURE_ROW       = 5'h0f;
  localparam int         SECURE_BASE_IDX  = 240;
  localparam int         PROTECT_BIT      = 4;
  localparam int         DIV_LOCK_BIT     = 7;
  localparam int         LATCH_BIT        = 2;
  localparam int         HV_BIT           = 0;
  localparam logic [7:0] ERASED_BYTE      = 8'hff;
  localparam logic [7:0] FACTORY_CFG      = 8'hf0;

  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [1:0] {
    OP_BYTE_PROGRAM = 2'b00,
    OP_BYTE_ERASE   = 2'b01,
    OP_BLOCK_ERASE  = 2'b10,
    OP_BULK_ERASE   = 2'b11
  } op_mode_t;

  typedef struct packed {
    logic spare;
    logic pad;
    logic power_down;
    logic erase_select_hi;
    logic erase_select_lo;
    logic bus_latch_bit;
    logic self_timed;
    logic high_voltage_enable;
  } ctl_t;

  typedef struct packed {
    logic        boot;
    ctl_t        ctl;
    logic        latched_valid;
    logic [9:0]  lat_addr;
    logic [7:0]  lat_data;
    logic [7:0]  cfg_live;
    logic [7:0]  div_high_live;
    logic [7:0]  div_low_live;
    logic        fail;
    logic [31:0] prdata;
    logic        pslverr;
  } state_t;

  typedef struct packed {
    logic [15:0] count;
    logic        elapsed;
  } timer_state_t;

  localparam state_t       STATE_RESET = '{boot: 1'b1, default: '0};
  localparam timer_state_t TIMER_RESET = '{default: '0};

endpackage

//--- nvm_op_timer.sv
/*
  operation timer: counts the documented time of the selected operation while
  the charge pump runs and flags when it has elapsed.
  assumes run and mode come from logic on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none

module nvm_op_timer (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              run,
  input  wire nvm_pkg::op_mode_t mode,
  output logic                   elapsed
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  nvm_pkg::timer_state_t s;
  nvm_pkg::timer_state_t next_s;
  logic [15:0]           target;

  function automatic logic [15:0] cycles_for(input nvm_pkg::op_mode_t m);
    unique case (m)
      nvm_pkg::OP_BYTE_PROGRAM: cycles_for = 16'(nvm_pkg::PROGRAM_CYCLES - 1);
      nvm_pkg::OP_BYTE_ERASE:   cycles_for = 16'(nvm_pkg::BYTE_ERASE_CYCLES - 1);
      nvm_pkg::OP_BLOCK_ERASE:  cycles_for = 16'(nvm_pkg::BLOCK_ERASE_CYCLES - 1);
      nvm_pkg::OP_BULK_ERASE:   cycles_for = 16'(nvm_pkg::BULK_ERASE_CYCLES - 1);
    endcase
  endfunction

  // ----------------------------------------
  // counter
  // ----------------------------------------
  always_comb begin
    target = cycles_for(mode);
    next_s = s;
    if (!run) begin
      next_s = nvm_pkg::TIMER_RESET;
    end else if (!s.elapsed) begin
      if (s.count == target) begin
        next_s.elapsed = 1'b1;
      end else begin
        next_s.count = s.count + 16'h0001;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s <= nvm_pkg::TIMER_RESET;
    end else begin
      s <= next_s;
    end
  end

  assign elapsed = s.elapsed;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  timer_clear_a: assert property (@(posedge clk) disable iff (rst)
    !run |=> !elapsed) else $error("timer flag survived a stop");

endmodule

`default_nettype wire

//--- eeprom_program_erase_protect.sv
/*
  eeprom program/erase/protect controller: 512-byte array, three nonvolatile
  configuration bytes, live copies, control register and apb slave.
  assumes an apb master on clk; the array keeps its contents over reset.
*/
// Decided for this implementation: the APB register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module eeprom_program_erase_protect (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [17:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  output logic             pump_on,
  output logic [10:0]      timebase_divider
);

  // ----------------------------------------
  // declarations
  // ----------------------------------------
  nvm_pkg::state_t   s;
  nvm_pkg::state_t   next_s;
  nvm_pkg::ctl_t     wctl;
  nvm_pkg::op_mode_t mode;
  logic [7:0]        mem [0:nvm_pkg::LAST_IDX];
  logic [15:0]       doc;
  logic              arr_hit;
  logic [9:0]        idx;
  logic              reg_hit;
  logic [7:0]        rd_val;
  logic              done;
  logic              wr;
  logic              rd;
  logic              ctl_wr;
  logic              arr_rd;
  logic              elapsed;
  logic              commit;
  logic              armed;
  logic              div_lock;
  logic [7:0]        cur_byte;
  logic [nvm_pkg::LAST_IDX:0] wr_en;
  logic [511:0]      prot_mask;

  // ----------------------------------------
  // decoding helpers
  // ----------------------------------------
  function automatic logic [10:0] decode_target(input logic [15:0] a);
    if (a >= nvm_pkg::ARRAY_BASE && a <= nvm_pkg::ARRAY_LAST) begin
      decode_target = {1'b1, 10'(a - nvm_pkg::ARRAY_BASE)};
    end else if (a == nvm_pkg::DIV_HIGH_NV_ADDR) begin
      decode_target = {1'b1, nvm_pkg::DIV_HIGH_NV_IDX};
    end else if (a == nvm_pkg::DIV_LOW_NV_ADDR) begin
      decode_target = {1'b1, nvm_pkg::DIV_LOW_NV_IDX};
    end else if (a == nvm_pkg::CFG_NV_ADDR) begin
      decode_target = {1'b1, nvm_pkg::CFG_NV_IDX};
    end else begin
      decode_target = 11'h000;
    end
  endfunction

  // whether byte i is changed by an operation aimed at t
  function automatic logic touches(input logic [9:0] i, input logic [9:0] t,
                                   input nvm_pkg::op_mode_t m, input logic [7:0] cfg,
                                   input logic arm, input logic dlock);
    logic sel;
    logic ok;
    sel = 1'b0;
    ok  = 1'b0;
    if (i < nvm_pkg::ARRAY_BYTES) begin
      unique case (m)
        nvm_pkg::OP_BULK_ERASE:  sel = t < nvm_pkg::ARRAY_BYTES;
        nvm_pkg::OP_BLOCK_ERASE: sel = t < nvm_pkg::ARRAY_BYTES && i[8:7] == t[8:7];
        default:                 sel = i == t;
      endcase
      ok = !cfg[i[8:7]]
           && !(arm && i[8:4] == nvm_pkg::SECURE_ROW)
           && !(arm && m[1]);
    end else begin
      sel = i == t && !m[1];
      ok  = (i == nvm_pkg::CFG_NV_IDX) ? !arm : !dlock;
    end
    touches = sel && ok;
  endfunction

  // ----------------------------------------
  // apb decode
  // ----------------------------------------
  assign doc      = paddr[17:2];
  assign {arr_hit, idx} = decode_target(doc);
  assign pready   = !s.boot;
  assign done     = psel && penable && pready;
  assign wr       = done && pwrite;
  assign rd       = done && !pwrite;
  assign ctl_wr   = wr && doc == nvm_pkg::CTL_ADDR && pstrb[0];
  assign arr_rd   = rd && arr_hit;
  assign wctl     = nvm_pkg::ctl_t'(pwdata[7:0]);
  assign mode     = nvm_pkg::op_mode_t'({s.ctl.erase_select_hi, s.ctl.erase_select_lo});
  assign armed    = !mem[nvm_pkg::CFG_NV_IDX][nvm_pkg::PROTECT_BIT];
  assign div_lock = !s.div_high_live[nvm_pkg::DIV_LOCK_BIT];
  assign cur_byte = mem[s.lat_addr];

  // ----------------------------------------
  // read mux
  // ----------------------------------------
  always_comb begin
    reg_hit = 1'b1;
    rd_val  = 8'h00;
    if (arr_hit) begin
      rd_val = s.ctl.bus_latch_bit ? s.lat_data : mem[idx];
    end else begin
      unique case (doc)
        nvm_pkg::DIV_HIGH_LIVE_ADDR: rd_val = {s.div_high_live[7], 4'h0,
                                               s.div_high_live[2:0]};
        nvm_pkg::DIV_LOW_LIVE_ADDR:  rd_val = s.div_low_live;
        nvm_pkg::CTL_ADDR:           rd_val = {s.ctl.spare, 1'b0, 6'(s.ctl)};
        nvm_pkg::CFG_LIVE_ADDR:      rd_val = s.cfg_live;
        default:                     reg_hit = 1'b0;
      endcase
    end
  end

  // ----------------------------------------
  // control state
  // ----------------------------------------
  always_comb begin
    next_s      = s;
    next_s.boot = 1'b0;
    if (s.boot) begin
      next_s.cfg_live      = mem[nvm_pkg::CFG_NV_IDX];
      next_s.div_high_live = mem[nvm_pkg::DIV_HIGH_NV_IDX];
      next_s.div_low_live  = mem[nvm_pkg::DIV_LOW_NV_IDX];
    end
    if (psel) begin
      next_s.prdata  = {24'h000000, rd_val};
      next_s.pslverr = !reg_hit && !arr_hit;
    end
    // latch address and data of valid array writes
    if (wr && arr_hit && pstrb[0] && s.ctl.bus_latch_bit
        && !s.ctl.high_voltage_enable) begin
      next_s.lat_addr      = idx;
      next_s.lat_data      = pwdata[7:0];
      next_s.latched_valid = 1'b1;
    end
    // control register, held off while latching without a valid latched address
    if (ctl_wr && (!s.ctl.bus_latch_bit || s.latched_valid)) begin
      if (s.ctl.high_voltage_enable) begin
        next_s.ctl.high_voltage_enable = wctl.high_voltage_enable;
      end else begin
        next_s.ctl     = wctl;
        next_s.ctl.pad = 1'b0;
        next_s.ctl.high_voltage_enable = wctl.high_voltage_enable
                                         && s.ctl.bus_latch_bit
                                         && s.latched_valid;
        if (!(wctl.bus_latch_bit && s.ctl.bus_latch_bit)) begin
          next_s.latched_valid = 1'b0;
        end
      end
    end
    // live divider, frozen while locked or latching
    if (wr && pstrb[0] && !s.ctl.bus_latch_bit && !div_lock) begin
      if (doc == nvm_pkg::DIV_HIGH_LIVE_ADDR) begin
        next_s.div_high_live = {pwdata[7], 4'h0, pwdata[2:0]};
      end
      if (doc == nvm_pkg::DIV_LOW_LIVE_ADDR) begin
        next_s.div_low_live = pwdata[7:0];
      end
    end
    if (rd && doc == nvm_pkg::CFG_NV_ADDR) begin
      next_s.cfg_live = mem[nvm_pkg::CFG_NV_IDX];
    end
    if (arr_rd && s.ctl.bus_latch_bit) begin
      next_s.lat_addr      = idx;
      next_s.latched_valid = 1'b1;
      if (s.ctl.high_voltage_enable) begin
        next_s.fail = 1'b1;
      end
    end
    if (s.ctl.high_voltage_enable && s.ctl.self_timed && elapsed) begin
      next_s.ctl.high_voltage_enable = 1'b0;
    end
    if (next_s.ctl.high_voltage_enable && !s.ctl.high_voltage_enable) begin
      next_s.fail = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s <= nvm_pkg::STATE_RESET;
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------
  // operation timer
  // ----------------------------------------
  nvm_op_timer u_timer (
    .clk     (clk),
    .rst     (rst),
    .run     (s.ctl.high_voltage_enable),
    .mode    (mode),
    .elapsed (elapsed)
  );

  assign commit = s.ctl.high_voltage_enable && !next_s.ctl.high_voltage_enable
                  && elapsed && !s.fail;

  // ----------------------------------------
  // array and nonvolatile bytes
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g <= nvm_pkg::LAST_IDX; g = g + 1) begin : g_en
      assign wr_en[g] = commit && touches(10'(g), s.lat_addr, mode, s.cfg_live,
                                          armed, div_lock);
    end
    for (g = 0; g < 512; g = g + 1) begin : g_prot
      assign prot_mask[g] = s.cfg_live[g / 128];
    end
  endgenerate

  initial begin
    for (int i = 0; i <= nvm_pkg::LAST_IDX; i++) begin
      mem[i] = nvm_pkg::ERASED_BYTE;
    end
    mem[nvm_pkg::CFG_NV_IDX] = nvm_pkg::FACTORY_CFG;
  end

  always @(posedge clk) begin
    for (int i = 0; i <= nvm_pkg::LAST_IDX; i++) begin
      if (wr_en[i]) begin
        if (mode == nvm_pkg::OP_BYTE_PROGRAM) begin
          mem[i] <= mem[i] & s.lat_data;
        end else begin
          mem[i] <= nvm_pkg::ERASED_BYTE;
        end
      end
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign prdata           = s.prdata;
  assign pslverr          = s.pslverr;
  assign pump_on          = s.ctl.high_voltage_enable;
  assign timebase_divider = {s.div_high_live[2:0], s.div_low_live};

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence ctl_write_s;
    ctl_wr;
  endsequence

  sequence pump_running_s;
    s.ctl.high_voltage_enable && s.ctl.self_timed && elapsed;
  endsequence

  secure_range_a: assert property (armed |-> wr_en[nvm_pkg::SECURE_BASE_IDX +: 16] == '0)
    else $error("secured byte modified while armed");

  nv_freeze_a: assert property (armed |-> !wr_en[nvm_pkg::CFG_NV_IDX])
    else $error("config nv byte modified while armed");

  bulk_block_off_a: assert property (armed && s.ctl.erase_select_hi |-> wr_en == '0)
    else $error("block or bulk erase while armed");

  block_guard_a: assert property ((wr_en[511:0] & prot_mask) == '0)
    else $error("protected block modified");

  program_down_a: assert property (commit && mode == nvm_pkg::OP_BYTE_PROGRAM
      && wr_en[s.lat_addr] |=> mem[$past(s.lat_addr)] == ($past(cur_byte) & $past(s.lat_data)))
    else $error("program result is not old and data");

  erase_ones_a: assert property (commit && mode != nvm_pkg::OP_BYTE_PROGRAM
      && wr_en[s.lat_addr] |=> mem[$past(s.lat_addr)] == nvm_pkg::ERASED_BYTE)
    else $error("erase left a zero bit");

  auto_stop_a: assert property (pump_running_s |=> !s.ctl.high_voltage_enable)
    else $error("self-timed cycle did not end");

  ctl_refuse_a: assert property (ctl_write_s ##0 (s.ctl.bus_latch_bit && !s.latched_valid)
      |=> $stable(s.ctl))
    else $error("control write taken before a valid latch");

  read_relatch_a: assert property (arr_rd && s.ctl.bus_latch_bit
      |=> s.lat_addr == $past(idx) && s.latched_valid)
    else $error("read did not relatch address");

  hv_refuse_a: assert property (ctl_write_s ##0 (!s.ctl.high_voltage_enable
      && !(s.ctl.bus_latch_bit && s.latched_valid)) |=> !s.ctl.high_voltage_enable)
    else $error("pump enabled without valid latch");

  latch_hold_a: assert property (ctl_write_s ##0 (s.ctl.high_voltage_enable
      && !pwdata[nvm_pkg::LATCH_BIT] && !pwdata[nvm_pkg::HV_BIT])
      |=> s.ctl.bus_latch_bit && !s.ctl.high_voltage_enable)
    else $error("latch dropped together with pump");

  cfg_reload_a: assert property (rd && doc == nvm_pkg::CFG_NV_ADDR
      |=> s.cfg_live == $past(mem[nvm_pkg::CFG_NV_IDX]))
    else $error("live config not reloaded on read");

  div_lock_a: assert property (s.boot && !mem[nvm_pkg::DIV_HIGH_NV_IDX][7]
      |=> div_lock [*2])
    else $error("divider not locked after reset");

  latched_read_a: assert property (psel && arr_hit && s.ctl.bus_latch_bit
      |=> prdata[7:0] == $past(s.lat_data))
    else $error("latched read returned array data");

  plain_read_a: assert property (psel && arr_hit && !s.ctl.bus_latch_bit
      |=> prdata[7:0] == $past(mem[idx]))
    else $error("array read returned wrong byte");

  latch_capture_a: assert property (wr && arr_hit && pstrb[0] && s.ctl.bus_latch_bit
      && !s.ctl.high_voltage_enable
      |=> s.latched_valid && s.lat_data == $past(pwdata[7:0]))
    else $error("valid array write not latched");

  div_freeze_a: assert property (div_lock && wr && doc == nvm_pkg::DIV_LOW_LIVE_ADDR
      |=> $stable(s.div_low_live))
    else $error("locked divider changed");

  div_nv_guard_a: assert property (div_lock |-> !wr_en[nvm_pkg::DIV_HIGH_NV_IDX]
      && !wr_en[nvm_pkg::DIV_LOW_NV_IDX])
    else $error("divider nv byte modified while locked");

  pump_drop_a: assert property (ctl_write_s ##0 (s.ctl.high_voltage_enable
      && !pwdata[nvm_pkg::HV_BIT]) |=> !pump_on)
    else $error("pump stayed on after clear");

endmodule

`default_nettype wire

//--- eeprom_cpu_model.sv
/*
  cpu-side apb master for the eeprom controller: one word per register index.
  assumes clk is shared with the controller and requests start after reset.
*/
`timescale 1ns/1ps
`default_nettype none

module eeprom_cpu_model (
  input  wire logic        clk,
  input  wire logic        pready,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [17:0]      paddr,
  output logic [31:0]      pwdata,
  output logic [3:0]       pstrb
);
  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 18'h00000;
    pwdata  = 32'h00000000;
    pstrb   = 4'h1;
  end

  // setup, then access held until pready is sampled high
  task automatic xfer(input logic w, input logic [15:0] idx, input logic [7:0] d);
    @(posedge clk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= {idx, 2'b00};
    pwdata <= {24'h000000, d};
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk iff pready);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule

`default_nettype wire

//--- eeprom_program_erase_protect_test.sv
/*
  self-checking bench for the eeprom controller: program, erase, latch,
  protection and security sequences. assumes the cpu model in its own file.
*/
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin num_errors++; \
  $display("[FAIL] %s expected %h seen %h", nm, ex, got); end end

module eeprom_program_erase_protect_test;
  localparam logic [15:0] CTL = nvm_pkg::CTL_ADDR;
  localparam logic [15:0] NV  = nvm_pkg::CFG_NV_ADDR;
  logic clk = 1'b0, rst = 1'b1;
  logic psel, penable, pwrite, pready, pslverr, pump_on;
  logic [17:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0]  pstrb;
  logic [10:0] tdiv;
  logic [8:0]  exq[$];
  logic [8:0]  e;
  int num_errors = 0, n_checks = 0, seed = 32'hf561, r;

  always #2.5 clk = ~clk;

  eeprom_program_erase_protect dut_u (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .pump_on(pump_on), .timebase_divider(tdiv));

  eeprom_cpu_model cpu_u (.clk(clk), .pready(pready), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb));

  // ----------------------------------------
  // read monitor: oldest note against the answer
  // ----------------------------------------
  always @(posedge clk) begin
    if (psel && penable && pready && !pwrite) begin
      if (exq.size() == 0) e = 9'h1ff;
      else e = exq.pop_front();
      `CHK("read data", e[7:0], prdata[7:0])
      `CHK("slave error", e[8], pslverr)
    end
  end

  task automatic rd(input logic [15:0] idx, input logic [7:0] x, input logic er = 1'b0);
    exq.push_back({er, x});
    cpu_u.xfer(1'b0, idx, 8'h00);
  endtask

  // select and latch, write target, enable, then timer or manual clear
  task automatic op(input logic [1:0] m, input logic a, input logic [15:0] idx,
                    input logic [7:0] d);
    int n;
    cpu_u.xfer(1'b1, CTL, {3'b000, m, 1'b1, a, 1'b0});
    cpu_u.xfer(1'b1, idx, d);
    cpu_u.xfer(1'b1, CTL, {3'b000, m, 1'b1, a, 1'b1});
    @(posedge clk);
    `CHK("pump on", 1'b1, pump_on)
    if (a) begin
      n = 0;
      while (pump_on === 1'b1 && n < 2100) begin
        @(posedge clk);
        n++;
      end
      `CHK("auto clear", 1'b0, pump_on)
    end else begin
      repeat (2010) @(posedge clk);
      cpu_u.xfer(1'b1, CTL, 8'h00);
      rd(CTL, {3'b000, m, 3'b100});
    end
    cpu_u.xfer(1'b1, CTL, 8'h00);
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge clk);
    num_errors++;
    finish_test();
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    rd(nvm_pkg::CFG_LIVE_ADDR, 8'hf0);
    rd(16'h0800, 8'hff);
    rd(16'hfe1e, 8'h00, 1'b1);
    cpu_u.xfer(1'b1, CTL, 8'h01);
    rd(CTL, 8'h00);
    $display("reset and refusal done");
    op(2'b00, 1'b0, 16'h0800, 8'h5a);
    rd(16'h0800, 8'h5a);
    op(2'b00, 1'b1, 16'h0800, 8'hfd);
    rd(16'h0800, 8'h58);
    op(2'b01, 1'b1, 16'h0800, 8'h00);
    rd(16'h0800, 8'hff);
    r = $random(seed);
    op(2'b00, 1'b1, 16'h0850, r[7:0]);
    rd(16'h0850, r[7:0]);
    op(2'b00, 1'b1, 16'h0801, 8'h00);
    op(2'b10, 1'b1, 16'h0800, 8'h00);
    rd(16'h0850, 8'hff);
    rd(16'h0801, 8'hff);
    $display("program and erase done");
    cpu_u.xfer(1'b1, CTL, 8'h04);
    cpu_u.xfer(1'b1, CTL, 8'h06);
    rd(CTL, 8'h04);
    cpu_u.xfer(1'b1, 16'h0810, 8'h33);
    cpu_u.xfer(1'b1, 16'h0811, 8'h44);
    rd(16'h0820, 8'h44);
    cpu_u.xfer(1'b1, CTL, 8'h05);
    repeat (2010) @(posedge clk);
    cpu_u.xfer(1'b1, CTL, 8'h04);
    cpu_u.xfer(1'b1, CTL, 8'h00);
    rd(16'h0820, 8'h44);
    rd(16'h0811, 8'hff);
    op(2'b11, 1'b1, 16'h0900, 8'h00);
    rd(16'h0820, 8'hff);
    $display("latch and bulk done");
    op(2'b00, 1'b1, 16'h0980, 8'h00);
    op(2'b01, 1'b1, NV, 8'h00);
    rd(NV, 8'hff);
    op(2'b01, 1'b1, 16'h0980, 8'h00);
    rd(16'h0980, 8'h00);
    op(2'b00, 1'b1, NV, 8'he0);
    rd(NV, 8'he0);
    rd(nvm_pkg::CFG_LIVE_ADDR, 8'he0);
    op(2'b01, 1'b1, 16'h0980, 8'h00);
    rd(16'h0980, 8'hff);
    op(2'b00, 1'b1, 16'h08f0, 8'h00);
    rd(16'h08f0, 8'hff);
    op(2'b00, 1'b1, 16'h0900, 8'h00);
    op(2'b10, 1'b1, 16'h0900, 8'h00);
    op(2'b11, 1'b1, 16'h0900, 8'h00);
    rd(16'h0900, 8'h00);
    op(2'b01, 1'b1, NV, 8'h00);
    rd(NV, 8'he0);
    $display("protection and security done");
    cpu_u.xfer(1'b1, 16'hfe1b, 8'h34);
    rd(16'hfe1b, 8'h34);
    `CHK("divider", 11'h734, tdiv)
    op(2'b00, 1'b1, 16'hfe10, 8'h7f);
    rst <= 1'b1;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    rd(16'hfe1a, 8'h07);
    cpu_u.xfer(1'b1, 16'hfe1b, 8'h12);
    rd(16'hfe1b, 8'hff);
    `CHK("divider locked", 11'h7ff, tdiv)
    rd(nvm_pkg::CFG_LIVE_ADDR, 8'he0);
    $display("divider lock done");
    repeat (3) @(posedge clk);
    finish_test();
  end
endmodule

`default_nettype wire
